// *** hdl/ring_kick_and_phy_mgmt.sv ***
// Purpose: ring kick flags, event flag and phy management frame engine
// Assumes: one clock at 25 MHz; descriptor status pulses come from logic on clk
// Notes: mdc and mdio drive come straight from flip-flops
`timescale 1ns/1ps
module ring_kick_and_phy_mgmt
  import ring_mgmt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire reg_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic rx_desc_empty,
  input wire logic tx_desc_not_ready,
  output logic rx_poll,
  output logic tx_poll,
  output logic irq,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic mdio_in
);
  localparam int START_BOUND = 140;

  logic enable_reg, enable_next;
  logic rx_kick_reg, rx_kick_next;
  logic tx_kick_reg, tx_kick_next;
  logic done_evt_reg, done_evt_next;
  logic done_mask_reg, done_mask_next;
  logic [31:0] frame_reg, frame_next;
  logic skip_reg, skip_next;
  logic [5:0] div_sw_reg, div_sw_next;
  logic [5:0] div_act_reg, div_act_next;
  logic [5:0] div_cnt_reg, div_cnt_next;
  logic mdc_reg, mdc_next;
  logic pend_reg, pend_next;
  mgmt_state_t state_reg, state_next;
  logic [4:0] idx_reg, idx_next;
  logic mdio_out_reg, mdio_out_next;
  logic mdio_oe_reg, mdio_oe_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rx_poll_reg, tx_poll_reg, irq_reg;
  logic sync1_reg, sync2_reg, sync3_reg, mdio_in_reg, mdio_in_next;
  logic wr_ctrl, wr_event, wr_mask, wr_rx, wr_tx, wr_frame, wr_clock;
  logic tick, fall, rise, is_read, done_set;

  always_comb begin
    wr_ctrl = bus_req.wr && (bus_req.addr == CTRL_OFS);
    wr_event = bus_req.wr && (bus_req.addr == EVENT_OFS);
    wr_mask = bus_req.wr && (bus_req.addr == MASK_OFS);
    wr_rx = bus_req.wr && (bus_req.addr == RX_KICK_OFS);
    wr_tx = bus_req.wr && (bus_req.addr == TX_KICK_OFS);
    wr_frame = bus_req.wr && (bus_req.addr == FRAME_OFS);
    wr_clock = bus_req.wr && (bus_req.addr == CLOCK_OFS);
  end

  // register file, ring kick flags and event flag
  always_comb begin
    enable_next = wr_ctrl ? bus_req.wdata[ENABLE_BIT] : enable_reg;
    rx_kick_next = rx_kick_reg;
    tx_kick_next = tx_kick_reg;
    if (rx_desc_empty && rx_poll_reg) begin
      rx_kick_next = 1'b0;
    end
    if (tx_desc_not_ready && tx_poll_reg) begin
      tx_kick_next = 1'b0;
    end
    // a kick write in the same cycle as a descriptor clear wins
    if (wr_rx) begin
      rx_kick_next = 1'b1;
    end
    if (wr_tx) begin
      tx_kick_next = 1'b1;
    end
    if (wr_ctrl && !bus_req.wdata[ENABLE_BIT]) begin
      rx_kick_next = 1'b0;
      tx_kick_next = 1'b0;
    end
    done_evt_next = done_evt_reg;
    if (wr_event && bus_req.wdata[MGMT_DONE_BIT]) begin
      done_evt_next = 1'b0;
    end
    if (done_set) begin
      done_evt_next = 1'b1;
    end
    done_mask_next = wr_mask ? bus_req.wdata[MGMT_DONE_BIT] : done_mask_reg;
    skip_next = wr_clock ? bus_req.wdata[SKIP_BIT] : skip_reg;
    div_sw_next = wr_clock ? bus_req.wdata[DIV_MSB:DIV_LSB] : div_sw_reg;
    rdata_next = ZERO_RESET;
    if (bus_req.rd) begin
      if (bus_req.addr == CTRL_OFS) begin
        rdata_next[ENABLE_BIT] = enable_reg;
      end else if (bus_req.addr == EVENT_OFS) begin
        rdata_next[MGMT_DONE_BIT] = done_evt_reg;
      end else if (bus_req.addr == MASK_OFS) begin
        rdata_next[MGMT_DONE_BIT] = done_mask_reg;
      end else if (bus_req.addr == RX_KICK_OFS) begin
        rdata_next[KICK_BIT] = rx_kick_reg;
      end else if (bus_req.addr == TX_KICK_OFS) begin
        rdata_next[KICK_BIT] = tx_kick_reg;
      end else if (bus_req.addr == FRAME_OFS) begin
        rdata_next = frame_reg;
      end else if (bus_req.addr == CLOCK_OFS) begin
        rdata_next[SKIP_BIT] = skip_reg;
        rdata_next[DIV_MSB:DIV_LSB] = div_sw_reg;
      end
    end
  end

  // mdc divider: half period is div_act_reg clocks, so duty stays at 50%
  always_comb begin
    tick = 1'b0;
    div_act_next = div_act_reg;
    div_cnt_next = div_cnt_reg;
    mdc_next = mdc_reg;
    if (div_act_reg == DIV_RESET) begin
      mdc_next = 1'b0;
      div_cnt_next = DIV_RESET;
      div_act_next = div_sw_reg;
    end else if (div_cnt_reg == div_act_reg - 6'h01) begin
      tick = 1'b1;
      div_cnt_next = DIV_RESET;
      // while mdc runs, a new divider only lands at the end of a half period
      div_act_next = div_sw_reg;
      mdc_next = (div_sw_reg == DIV_RESET) ? 1'b0 : !mdc_reg;
    end else begin
      div_cnt_next = div_cnt_reg + 6'h01;
    end
    fall = tick && mdc_reg;
    rise = tick && !mdc_reg;
  end

  // frame engine: drive on falling mdc, sample on rising mdc
  always_comb begin
    // opcode field: bit 2 leaves first, so wire 10 (read) is bit2=1, bit3=0
    is_read = frame_reg[OP_LSB] && !frame_reg[OP_LSB + 1];
    state_next = state_reg;
    idx_next = idx_reg;
    frame_next = wr_frame ? bus_req.wdata : frame_reg;
    pend_next = pend_reg;
    mdio_out_next = mdio_out_reg;
    mdio_oe_next = mdio_oe_reg;
    done_set = 1'b0;
    mdio_in_next = (sync2_reg == sync3_reg) ? sync3_reg : mdio_in_reg;
    case (state_reg)
      MG_IDLE: begin
        if (fall && pend_reg) begin
          pend_next = 1'b0;
          idx_next = 5'h00;
          mdio_oe_next = 1'b1;
          if (skip_reg) begin
            state_next = MG_FRAME;
            mdio_out_next = frame_reg[0];
          end else begin
            state_next = MG_PREAMBLE;
            mdio_out_next = 1'b1;
          end
        end
      end
      MG_PREAMBLE: begin
        if (fall) begin
          if (idx_reg == PREAMBLE_LAST) begin
            state_next = MG_FRAME;
            idx_next = 5'h00;
            mdio_out_next = frame_reg[0];
          end else begin
            idx_next = idx_reg + 5'h01;
          end
        end
      end
      MG_FRAME: begin
        if (fall) begin
          if (idx_reg == FRAME_LAST) begin
            state_next = MG_IDLE;
            mdio_oe_next = 1'b0;
            mdio_out_next = 1'b0;
            done_set = 1'b1;
          end else begin
            idx_next = idx_reg + 5'h01;
            mdio_out_next = frame_reg[idx_reg + 5'h01];
            mdio_oe_next = !(is_read && (idx_reg + 5'h01 >= TA_IDX));
          end
        end else if (rise && is_read && idx_reg >= DATA_IDX && !wr_frame) begin
          // first sampled bit, the data msb, lands in bit 16, the lowest bit of the data field
          frame_next[idx_reg] = mdio_in_reg;
        end
      end
      default: begin
        state_next = MG_IDLE;
      end
    endcase
    if (wr_frame) begin
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    sync1_reg <= mdio_in;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
    frame_reg <= frame_next;
    if (!rst_b) begin
      enable_reg <= 1'b0;
      rx_kick_reg <= 1'b0;
      tx_kick_reg <= 1'b0;
      done_evt_reg <= 1'b0;
      done_mask_reg <= 1'b0;
      skip_reg <= 1'b0;
      div_sw_reg <= DIV_RESET;
      div_act_reg <= DIV_RESET;
      div_cnt_reg <= DIV_RESET;
      mdc_reg <= 1'b0;
      pend_reg <= 1'b0;
      state_reg <= MG_IDLE;
      idx_reg <= 5'h00;
      mdio_out_reg <= 1'b0;
      mdio_oe_reg <= 1'b0;
      rdata_reg <= ZERO_RESET;
      rx_poll_reg <= 1'b0;
      tx_poll_reg <= 1'b0;
      irq_reg <= 1'b0;
      mdio_in_reg <= 1'b1;
    end else begin
      enable_reg <= enable_next;
      rx_kick_reg <= rx_kick_next;
      tx_kick_reg <= tx_kick_next;
      done_evt_reg <= done_evt_next;
      done_mask_reg <= done_mask_next;
      skip_reg <= skip_next;
      div_sw_reg <= div_sw_next;
      div_act_reg <= div_act_next;
      div_cnt_reg <= div_cnt_next;
      mdc_reg <= mdc_next;
      pend_reg <= pend_next;
      state_reg <= state_next;
      idx_reg <= idx_next;
      mdio_out_reg <= mdio_out_next;
      mdio_oe_reg <= mdio_oe_next;
      rdata_reg <= rdata_next;
      rx_poll_reg <= rx_kick_next && enable_next;
      tx_poll_reg <= tx_kick_next && enable_next;
      irq_reg <= done_evt_next && done_mask_next;
      mdio_in_reg <= mdio_in_next;
    end
  end

  assign rdata = rdata_reg;
  assign rx_poll = rx_poll_reg;
  assign tx_poll = tx_poll_reg;
  assign irq = irq_reg;
  assign mdc = mdc_reg;
  assign mdio_out = mdio_out_reg;
  assign mdio_oe = mdio_oe_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_last_bit_fall;
    state_reg == MG_FRAME && idx_reg == FRAME_LAST && fall;
  endsequence
  sequence s_done_seen;
    done_evt_reg && state_reg == MG_IDLE;
  endsequence

  property p_rx_kick_set;
    wr_rx |=> rx_kick_reg;
  endproperty
  a_rx_kick_set: assert property (p_rx_kick_set) else $error("rx kick not set");
  property p_tx_kick_set;
    wr_tx |=> tx_kick_reg;
  endproperty
  a_tx_kick_set: assert property (p_tx_kick_set) else $error("tx kick not set");
  property p_kick_off_disable;
    $fell(enable_reg) |-> (!rx_kick_reg && !tx_kick_reg) ##1 (!rx_poll_reg && !tx_poll_reg);
  endproperty
  a_kick_off_disable: assert property (p_kick_off_disable) else $error("kick survives");
  property p_rx_stop;
    rx_poll_reg && rx_desc_empty && !wr_rx |=> !rx_kick_reg && !rx_poll_reg;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx polling not stopped");
  property p_tx_stop;
    tx_poll_reg && tx_desc_not_ready && !wr_tx |=> !tx_kick_reg && !tx_poll_reg;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx polling not stopped");
  property p_mdc_parked;
    (div_act_reg == DIV_RESET) [*2] |-> !mdc_reg;
  endproperty
  a_mdc_parked: assert property (p_mdc_parked) else $error("mdc runs with zero divider");
  property p_start_soon;
    wr_frame && state_reg == MG_IDLE && div_sw_reg != DIV_RESET && !wr_clock
      ##1 (div_sw_reg != DIV_RESET) [*2] |-> ##[1:START_BOUND] state_reg != MG_IDLE;
  endproperty
  a_start_soon: assert property (p_start_soon) else $error("frame did not start");
  property p_done_event;
    s_last_bit_fall |=> s_done_seen;
  endproperty
  a_done_event: assert property (p_done_event) else $error("no done event");
  property p_write_keeps;
    state_reg == MG_FRAME && !is_read && !wr_frame |=> $stable(frame_reg);
  endproperty
  a_write_keeps: assert property (p_write_keeps) else $error("write frame altered");
  property p_event_clear;
    wr_event && bus_req.wdata[MGMT_DONE_BIT] && !done_set |=> !done_evt_reg;
  endproperty
  a_event_clear: assert property (p_event_clear) else $error("event not cleared");
  property p_skip;
    state_reg == MG_IDLE && fall && pend_reg && skip_reg |=> state_reg == MG_FRAME;
  endproperty
  a_skip: assert property (p_skip) else $error("preamble not skipped");
  property p_release;
    state_reg == MG_FRAME && is_read && idx_reg >= TA_IDX |-> !mdio_oe_reg;
  endproperty
  a_release: assert property (p_release) else $error("mdio driven in read");
endmodule // ring_kick_and_phy_mgmt

// *** include/ring_mgmt_pkg.sv ***
// Purpose: constants and types for the ring kick flags and phy management engine
// Assumes: bit n of a register is bit n of the 32-bit bus word
// Notes: offsets are byte addresses on the plain register port
package ring_mgmt_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'he40;
  localparam logic [11:0] EVENT_OFS = 12'he44;
  localparam logic [11:0] MASK_OFS = 12'he48;
  localparam logic [11:0] RX_KICK_OFS = 12'he50;
  localparam logic [11:0] TX_KICK_OFS = 12'he54;
  localparam logic [11:0] FRAME_OFS = 12'he80;
  localparam logic [11:0] CLOCK_OFS = 12'he84;
  localparam int unsigned ENABLE_BIT = 30;
  localparam int unsigned KICK_BIT = 7;
  localparam int unsigned MGMT_DONE_BIT = 8;
  localparam int unsigned SKIP_BIT = 24;
  localparam int unsigned DIV_LSB = 25;
  localparam int unsigned DIV_MSB = 30;
  localparam int unsigned OP_LSB = 2;
  localparam int unsigned TA_LSB = 14;
  localparam int unsigned DATA_LSB = 16;
  localparam logic [4:0] PREAMBLE_LAST = 5'h1f;
  localparam logic [4:0] FRAME_LAST = 5'h1f;
  localparam logic [4:0] TA_IDX = 5'h0e;
  localparam logic [4:0] DATA_IDX = 5'h10;
  localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
  localparam logic [5:0] DIV_RESET = 6'h00;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    MG_IDLE = 2'b00,
    MG_PREAMBLE = 2'b01,
    MG_FRAME = 2'b10
  } mgmt_state_t;
endpackage

// *** verification/phy_mgmt_model.sv ***
// Purpose: behavioural phy on the management link, answers read frames
// Assumes: mdio wire has a pull-up, so a released line reads 1
// Notes: syncs on the first 0 after ones; bits collected in send order
`timescale 1ns/1ps
module phy_mgmt_model (
  input wire logic mdc,
  input wire logic mdio,
  input wire logic [15:0] rd_val,
  output logic drv_oe,
  output logic drv_val,
  output logic [31:0] seen_bits
);
  logic active;
  int cnt;
  initial begin
    active = 1'b0;
    cnt = 0;
    drv_oe = 1'b0;
    drv_val = 1'b1;
    seen_bits = 32'h0000_0000;
  end
  // bit n of the frame word is the n-th bit on the wire
  always @(posedge mdc) begin
    if (!active) begin
      if (mdio === 1'b0) begin
        active = 1'b1;
        cnt = 1;
        seen_bits = 32'h0000_0000;
      end
    end else begin
      seen_bits[cnt] = mdio;
      cnt++;
      if (cnt == 32) active = 1'b0;
    end
  end
  // read opcode: drive 0 on second turnaround bit, then data msb first
  always @(negedge mdc) begin
    if (active && seen_bits[3:2] == 2'b01 && cnt >= 15) begin
      drv_oe = 1'b1;
      drv_val = (cnt == 15) ? 1'b0 : rd_val[31-cnt];
    end else drv_oe = 1'b0;
  end
endmodule // phy_mgmt_model

// *** verification/tb_ring_kick_and_phy_mgmt.sv ***
// Purpose: self-checking bench for ring kick flags and management frames
// Assumes: divider kept at 5 or more so mdc stays at or below 2.5 MHz
// Notes: mdio modelled with a pull-up; random data from an xorshift
`timescale 1ns/1ps
module tb_ring_kick_and_phy_mgmt;
  import ring_mgmt_pkg::*;
  logic clk, rst_b, rx_desc_empty, tx_desc_not_ready, rx_poll, tx_poll, irq;
  logic mdc, mdio_out, mdio_oe, mdio_wire, phy_oe, phy_val, mdc_q, mdc_chk;
  reg_req_t bus_req;
  logic [31:0] rdata, rd, f, seed, seen_bits;
  logic [15:0] phy_data;
  logic [11:0] ka;
  logic [5:0] cur_div;
  logic [11:0] ofs [4] = '{RX_KICK_OFS, TX_KICK_OFS, CLOCK_OFS, 12'he60};
  int mismatches = 0;
  int total_checks = 0;
  int oe_rises = 0;
  int run = 0;
  // released line floats up, so the far side never sees a stale value
  assign mdio_wire = mdio_oe ? mdio_out : (phy_oe ? phy_val : 1'b1);
  ring_kick_and_phy_mgmt uut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
    .rx_desc_empty(rx_desc_empty), .tx_desc_not_ready(tx_desc_not_ready),
    .rx_poll(rx_poll), .tx_poll(tx_poll), .irq(irq), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mdio_in(mdio_wire));
  phy_mgmt_model phy (.mdc(mdc), .mdio(mdio_wire), .rd_val(phy_data), .drv_oe(phy_oe),
    .drv_val(phy_val), .seen_bits(seen_bits));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] frame_word(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] d);
    return {d, 2'b01, ra, pa, op, 2'b10};
  endfunction
  function automatic logic [31:0] read_result(input logic [31:0] w, input logic [15:0] d);
    logic [31:0] r;
    r = w;
    // phy data comes msb first and the first data bit on the wire is frame bit 16
    for (int k = 0; k < 16; k++) begin
      r[16 + k] = d[15 - k];
    end
    return r;
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[MGMT_DONE_BIT] !== 1'b1 && n < 400) begin
      bus_rd(EVENT_OFS, rd);
      n++;
    end
    check("done event", rd, 32'h100);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // half periods of mdc measured in clocks; only full runs are judged
  always @(posedge clk) begin
    if (mdc !== mdc_q) begin
      if (mdc_chk) check("mdc half period", 32'(run), {26'h0, cur_div});
      if (mdc === 1'b1 && mdio_oe === 1'b1) oe_rises++;
      run = 1;
    end else run++;
    mdc_q = mdc;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    rx_desc_empty = 1'b0;
    tx_desc_not_ready = 1'b0;
    phy_data = 16'h0000;
    seed = 32'd70;
    mdc_q = 1'b0;
    mdc_chk = 1'b0;
    cur_div = 6'h00;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ofs[i]) begin
      bus_rd(ofs[i], rd);
      check("reset or unmapped value", rd, ZERO_RESET);
    end
    $display("test reset done");
    bus_wr(CTRL_OFS, 32'h4000_0000);
    for (int i = 0; i < 2; i++) begin
      seed = nxt(seed);
      ka = (i == 0) ? RX_KICK_OFS : TX_KICK_OFS;
      bus_wr(ka, (i == 0) ? 32'h0000_0000 : seed);
      bus_rd(ka, rd);
      check("kick flag", rd, 32'h80);
      check("poll on", {30'h0, rx_poll, tx_poll}, (i == 0) ? 32'h2 : 32'h1);
      @(posedge clk);
      rx_desc_empty <= (i == 0);
      tx_desc_not_ready <= (i == 1);
      @(posedge clk);
      rx_desc_empty <= 1'b0;
      tx_desc_not_ready <= 1'b0;
      bus_rd(ka, rd);
      check("kick cleared", rd, 32'h0);
      check("poll off", {30'h0, rx_poll, tx_poll}, 32'h0);
    end
    bus_wr(RX_KICK_OFS, 32'hffff_ffff);
    bus_wr(TX_KICK_OFS, 32'h0000_0000);
    bus_wr(CTRL_OFS, 32'h0000_0000);
    bus_rd(RX_KICK_OFS, rd);
    check("rx kick after disable", rd, 32'h0);
    bus_rd(TX_KICK_OFS, rd);
    check("tx kick after disable", rd, 32'h0);
    bus_wr(RX_KICK_OFS, 32'h1);
    bus_rd(TX_KICK_OFS, rd);
    check("poll while disabled", {30'h0, rx_poll, tx_poll}, 32'h0);
    $display("test kick done");
    bus_wr(MASK_OFS, 32'h100);
    seed = nxt(seed);
    f = frame_word(2'b10, seed[4:0], seed[9:5], seed[31:16]);
    bus_wr(FRAME_OFS, f);
    repeat (20) @(posedge clk);
    #1;
    check("idle with divider zero", {30'h0, mdc, mdio_oe}, 32'h0);
    oe_rises = 0;
    cur_div = 6'h05;
    bus_wr(CLOCK_OFS, {1'b0, cur_div, 25'h0});
    bus_rd(CLOCK_OFS, rd);
    check("clock ctrl", rd, {1'b0, cur_div, 25'h0});
    repeat (24) @(posedge clk);
    #1;
    mdc_chk = 1'b1;
    wait_done();
    mdc_chk = 1'b0;
    check("write frame on wire", seen_bits, f);
    check("oe rises with preamble", 32'(oe_rises), 32'd64);
    bus_rd(FRAME_OFS, rd);
    check("frame kept", rd, f);
    check("irq raised", {31'h0, irq}, 32'h1);
    bus_wr(EVENT_OFS, 32'h0000_0000);
    bus_rd(EVENT_OFS, rd);
    check("event kept on zero write", rd, 32'h100);
    bus_wr(EVENT_OFS, 32'h100);
    bus_rd(EVENT_OFS, rd);
    check("event cleared", rd, 32'h0);
    check("irq dropped", {31'h0, irq}, 32'h0);
    $display("test write frame done");
    bus_wr(MASK_OFS, 32'h0);
    seed = nxt(seed);
    phy_data = seed[15:0];
    f = frame_word(2'b01, seed[20:16], seed[25:21], 16'hffff);
    cur_div = 6'h06;
    bus_wr(CLOCK_OFS, {1'b0, cur_div, 1'b1, 24'h0});
    oe_rises = 0;
    bus_wr(FRAME_OFS, f);
    repeat (40) @(posedge clk);
    #1;
    mdc_chk = 1'b1;
    wait_done();
    mdc_chk = 1'b0;
    check("oe rises without preamble", 32'(oe_rises), 32'd14);
    check("irq masked", {31'h0, irq}, 32'h0);
    check("read header on wire", {18'h0, seen_bits[13:0]}, {18'h0, f[13:0]});
    bus_rd(FRAME_OFS, rd);
    check("read frame result", rd, read_result(f, phy_data));
    bus_wr(EVENT_OFS, 32'h100);
    bus_wr(CLOCK_OFS, 32'h0);
    repeat (30) @(posedge clk);
    #1;
    check("mdc parked", {31'h0, mdc}, 32'h0);
    $display("test read frame done");
    close_out();
  end
endmodule // tb_ring_kick_and_phy_mgmt
